// ---- rtl/video_redundancy_reducer.sv ----
module video_redundancy_reducer
  import reducer_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] rate_sel_in,
  input wire logic [5:0] sample_in,
  input wire logic interpolator_mode_in,
  input wire logic [1:0] tag_size_in,
  input wire logic tol_adaptive_in,
  input wire logic [3:0] tol_fixed_in,
  input wire logic [3:0] fill_tol_in,
  input wire logic hblank_in,
  input wire logic vblank_in,
  input wire logic buf_ready_in,
  input wire logic underflow_in,
  output logic [9:0] word_out,
  output logic word_valid_out,
  input wire logic word_ready_in
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    red_state_t st;
    logic [5:0] div;
    logic [5:0] u;
    logic [5:0] l;
    logic [5:0] tag;
    logic first;
    logic vkind;
  } red_regs_t;

  red_regs_t s_q;
  red_regs_t s_d;

  logic tick;
  logic blank;
  logic [5:0] period_m1;
  logic [3:0] tol;
  logic [6:0] up_sum;
  logic [5:0] ub;
  logic [5:0] lb;
  logic overlap;
  logic [6:0] mid_sum;
  logic [5:0] mid;
  logic [5:0] limit;
  logic force_nr;
  logic [9:0] video_word;
  logic [9:0] sync_word;
  logic [5:0] load_u;
  logic [5:0] load_l;
  logic push_v;
  logic [9:0] push_d;
  logic fifo_rdy;
  logic redun;
  logic step_emit;
  logic emit;

  // ****************************************
  // sample rate divider
  // ****************************************
  assign period_m1 = period_cycles(rate_sel_in) - 6'h01;
  assign tick = (s_q.div == 6'h00);
  assign blank = hblank_in | vblank_in;

  // ****************************************
  // shared datapath
  // ****************************************
  assign tol = tol_adaptive_in ? fill_tol_in : tol_fixed_in;
  assign up_sum = {1'b0, sample_in} + {3'h0, tol};
  assign ub = up_sum[6] ? SAMPLE_MAX : up_sum[5:0];
  assign lb = ({2'h0, tol} > sample_in) ? 6'h00 : sample_in - {2'h0, tol};
  // one add for the upper bound and one subtract for the lower, then two compares for the overlap
  assign overlap = (ub >= s_q.l) && (lb <= s_q.u);
  assign mid_sum = {1'b0, s_q.u} + {1'b0, s_q.l};
  assign mid = mid_sum[6:1];

  always_comb
  begin
    case (tag_size_in)
      TAG_SEL_5:
      begin
        limit = RUN_LIMIT_5;
        video_word = {mid[5:1], s_q.tag[4:0]};
      end
      TAG_SEL_6:
      begin
        limit = RUN_LIMIT_6;
        video_word = {mid[5:2], s_q.tag[5:0]};
      end
      default:
      begin
        limit = RUN_LIMIT_4;
        video_word = {mid, s_q.tag[3:0]};
      end
    endcase
  end

  assign force_nr = underflow_in || (s_q.tag >= limit);
  assign sync_word = {s_q.vkind ? VSYNC_AMP : HSYNC_AMP, 6'h00};
  // mode changes what is gated into the corridor and whether it narrows on redundant
  assign load_u = interpolator_mode_in ? ub : sample_in;
  assign load_l = interpolator_mode_in ? lb : sample_in;
  assign emit = push_v && fifo_rdy && (s_q.st == ST_ACTIVE);

  // ****************************************
  // control
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    push_v = 1'b0;
    push_d = video_word;
    redun = 1'b0;
    step_emit = 1'b0;
    // divider runs in every state so ticks keep their phase through blanking
    s_d.div = tick ? period_m1 : s_q.div - 6'h01;
    case (s_q.st)
      ST_ACTIVE:
      begin
        if (blank)
        begin
          if (s_q.first)
          begin
            s_d.st = ST_SYNC;
            s_d.vkind = vblank_in;
          end
          else
          begin
            push_v = 1'b1;
            if (fifo_rdy)
            begin
              s_d.tag = 6'h00;
              s_d.st = ST_SYNC;
              s_d.vkind = vblank_in;
            end
          end
        end
        else if (tick)
        begin
          if (s_q.first)
          begin
            s_d.u = load_u;
            s_d.l = load_l;
            s_d.first = 1'b0;
          end
          else if (overlap && !force_nr)
          begin
            redun = 1'b1;
            s_d.tag = s_q.tag + 6'h01;
            if (interpolator_mode_in)
            begin
              s_d.u = (ub < s_q.u) ? ub : s_q.u;
              s_d.l = (lb > s_q.l) ? lb : s_q.l;
            end
          end
          else
          begin
            // a full buffer stalls the step and the sample is lost
            push_v = 1'b1;
            if (fifo_rdy)
            begin
              step_emit = 1'b1;
              s_d.tag = 6'h00;
              s_d.u = load_u;
              s_d.l = load_l;
            end
          end
        end
      end
      ST_SYNC:
      begin
        // sync load waits on the buffer's ready level
        if (buf_ready_in)
        begin
          push_v = 1'b1;
          push_d = sync_word;
          if (fifo_rdy)
          begin
            s_d.st = ST_SPARE;
          end
        end
      end
      ST_SPARE:
      begin
        push_v = 1'b1;
        push_d = SPARE_WORD;
        if (fifo_rdy)
        begin
          s_d.st = ST_BLANKED;
        end
      end
      ST_BLANKED:
      begin
        if (!blank)
        begin
          s_d.st = ST_ACTIVE;
          s_d.first = 1'b1;
        end
      end
      default:
      begin
        s_d.st = ST_BLANKED;
      end
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      s_q <= '{st: ST_BLANKED, div: DIV_RESET, u: 6'h00, l: 6'h00, tag: 6'h00, first: 1'b1, vkind: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // output buffer
  // ****************************************
  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .in_data_in(push_d),
    .in_valid_in(push_v),
    .in_ready_out(fifo_rdy),
    .out_data_out(word_out),
    .out_valid_out(word_valid_out),
    .out_ready_in(word_ready_in)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence sync_push_s;
    push_v && fifo_rdy && (s_q.st == ST_SYNC);
  endsequence

  sequence first_step_s;
    tick && s_q.first && !blank && (s_q.st == ST_ACTIVE);
  endsequence

  sample_period_a: assert property (tick |=> s_q.div == $past(period_m1))
    else $error("sample period reload wrong");
  pack4_a: assert property (emit && tag_size_in == TAG_SEL_4 |-> push_d == {mid, s_q.tag[3:0]})
    else $error("4-bit tag word packing wrong");
  pack5_a: assert property (emit && tag_size_in == TAG_SEL_5 |-> push_d[4:0] == s_q.tag[4:0])
    else $error("5-bit tag word packing wrong");
  pack6_a: assert property (emit && tag_size_in == TAG_SEL_6 |-> push_d[5:0] == s_q.tag)
    else $error("6-bit tag word packing wrong");
  interp_load_a: assert property (step_emit && interpolator_mode_in |=> s_q.u == $past(ub) && s_q.l == $past(lb))
    else $error("interpolator corridor not loaded");
  tag_count_a: assert property (redun |=> s_q.tag == $past(s_q.tag) + 6'h01)
    else $error("time tag not incremented");
  corridor_narrow_a: assert property (redun && interpolator_mode_in |=> s_q.u <= $past(s_q.u) && s_q.l >= $past(s_q.l))
    else $error("corridor widened on redundant sample");
  midpoint_out_a: assert property (emit |-> push_d[9:6] == mid[5:2])
    else $error("emitted value is not corridor midpoint");
  run_limit_a: assert property (tick && !blank && !s_q.first && s_q.tag == limit |-> !redun)
    else $error("run limit not enforced");
  pred_hold_a: assert property (redun && !interpolator_mode_in |=> $stable(s_q.u) && $stable(s_q.l))
    else $error("predictor corridor changed on redundant");
  pred_check_a: assert property (redun && !interpolator_mode_in |-> s_q.u >= lb && s_q.u <= ub)
    else $error("predictor redundancy outside range");
  blank_flush_a: assert property (s_q.st == ST_ACTIVE && blank && !s_q.first && fifo_rdy |-> emit ##1 s_q.st == ST_SYNC)
    else $error("blanking did not flush corridor");
  sync_order_a: assert property (sync_push_s |=> s_q.st == ST_SPARE ##0 push_d == SPARE_WORD)
    else $error("spare word does not follow sync word");
  sync_gate_a: assert property (push_v && s_q.st == ST_SYNC |-> buf_ready_in)
    else $error("sync word offered without buffer ready");
  sync_format_a: assert property (sync_push_s |-> push_d[5:0] == 6'h00 && push_d[9:6] != 4'h0)
    else $error("sync word format wrong");
  underflow_force_a: assert property (tick && !blank && !s_q.first && underflow_in |-> !redun)
    else $error("underflow did not force nonredundant");
  first_init_a: assert property (first_step_s |-> !push_v ##1 !s_q.first && s_q.u == $past(load_u))
    else $error("first sample not used to initialise");
  tag_clear_a: assert property (step_emit |=> s_q.tag == 6'h00)
    else $error("tag not cleared after emit");

  // ****************************************
  // corridor, blanking, packing, forcing and tolerance checks
  // ****************************************
  sequence flush_push_s;
    push_v && fifo_rdy && (s_q.st == ST_ACTIVE) && blank && !s_q.first;
  endsequence

  sequence spare_push_s;
    push_v && fifo_rdy && (s_q.st == ST_SPARE);
  endsequence

  sequence drop_s;
    tick && push_v && !fifo_rdy && !blank && (s_q.st == ST_ACTIVE);
  endsequence

  sequence live_tick_s;
    tick && !blank && !s_q.first && (s_q.st == ST_ACTIVE);
  endsequence

  corridor_order_a: assert property (s_q.u >= s_q.l)
    else $error("corridor upper below lower");
  pred_load_a: assert property (step_emit && !interpolator_mode_in |=> s_q.u == $past(sample_in) && s_q.l == $past(sample_in))
    else $error("predictor corridor not loaded with sample");
  bound_order_a: assert property (lb <= sample_in && ub >= sample_in)
    else $error("tolerance bounds do not enclose sample");
  blank_quiet_a: assert property (s_q.st == ST_BLANKED |-> !push_v)
    else $error("word written while blanked");
  halt_blank_a: assert property (s_q.st != ST_ACTIVE |-> !redun && !step_emit)
    else $error("reduction ran outside active video");
  spare_word_a: assert property (s_q.st == ST_SPARE |-> push_v && push_d == SPARE_WORD)
    else $error("spare word not offered");
  sync_kind_a: assert property (s_q.st == ST_ACTIVE && blank && (s_q.first || fifo_rdy) |=> s_q.vkind == $past(vblank_in))
    else $error("sync kind not taken at blanking onset");
  first_set_a: assert property (s_q.st == ST_BLANKED && !blank |=> s_q.first && s_q.st == ST_ACTIVE)
    else $error("first-sample flag not set after blanking");
  tag_bound_a: assert property (s_q.tag <= RUN_LIMIT_6)
    else $error("time tag beyond longest run");
  flush_clear_a: assert property (flush_push_s |=> s_q.tag == 6'h00 && s_q.st == ST_SYNC)
    else $error("flush did not clear tag");
  spare_next_a: assert property (spare_push_s |=> s_q.st == ST_BLANKED)
    else $error("extra word after spare word");
  full_hold_a: assert property (drop_s |=> $stable(s_q.tag) && $stable(s_q.u) && $stable(s_q.l))
    else $error("state changed on dropped sample");
  pack_code3_a: assert property (emit && tag_size_in == 2'h3 |-> push_d == {mid, s_q.tag[3:0]})
    else $error("tag size code 3 not packed as 4-bit");
  mid_inside_a: assert property (emit |-> mid >= s_q.l && mid <= s_q.u)
    else $error("midpoint outside corridor");
  sync_hold_a: assert property (s_q.st == ST_SYNC && !buf_ready_in |=> s_q.st == ST_SYNC)
    else $error("sync left without buffer ready");
  underflow_emit_a: assert property (live_tick_s ##0 underflow_in |-> push_v)
    else $error("underflow sample not offered");
  limit_emit_a: assert property (live_tick_s ##0 s_q.tag >= limit |-> push_v)
    else $error("run limit sample not offered");
  redun_step_a: assert property (redun |-> tick && overlap && s_q.st == ST_ACTIVE)
    else $error("redundant without overlap");
  emit_cause_a: assert property (step_emit |-> !overlap || force_nr)
    else $error("word emitted on overlapping sample");
  tol_select_a: assert property (tol_adaptive_in |-> tol == fill_tol_in)
    else $error("adaptive tolerance not selected");
endmodule : video_redundancy_reducer

// ---- rtl/reducer_pkg.sv ----
// Operation
// - take one 6-bit sample each sample period; rate selectable 1 to 9 MHz
// - tolerance is 4 bits, fixed or driven by buffer fill rate
// - every emitted word is 10 bits: 6+4, 5+5 or 4+6 split
// - 4-bit tag keeps the full 6-bit sample beside the 4-bit count
// - 5-bit tag keeps sample bits 5..1, count msb takes sample lsb place
// - 6-bit tag keeps sample bits 5..2, two count msbs take freed places
// - each step is one add or subtract then one compare, shared datapath; the code does one add and one subtract, then two compares
// - interpolator loads upper and lower bounds into the corridor after nonredundant
// - overlap of sample range and corridor means redundant; tag increments
// - interpolator narrows corridor on redundant: lower upper, higher lower
// - no overlap emits corridor midpoint (upper plus lower halved) with tag
// - run of 14, 30 or 62 forces nonredundant for tags 4, 5, 6
// - predictor loads sample into both bounds after nonredundant, never on redundant
// - predictor is redundant when stored start value lies in sample range
// - blanking onset forces present sample nonredundant, then halts until blanking ends
// - during blanking write only horizontal or vertical sync word, then spare word
// - buffer signals readiness for sync load; sync word first, spare word after
// - sync words carry zero 6-bit tag and 4-bit amplitude, split independent
// - buffer underflow in active video forces present sample nonredundant
// - first sample after blanking skips reduction and initialises corridor per mode
package reducer_pkg;
  localparam int CLK_FREQ_MHZ = 50;
  localparam int SAMPLE_W = 6;
  localparam int TOL_W = 4;
  localparam int TAG_W = 6;
  localparam int WORD_W = 10;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] RATE_MIN_MHZ = 4'h1;
  localparam logic [3:0] RATE_MAX_MHZ = 4'h9;
  localparam logic [5:0] SAMPLE_MAX = 6'h3f;
  localparam logic [1:0] TAG_SEL_4 = 2'h0;
  localparam logic [1:0] TAG_SEL_5 = 2'h1;
  localparam logic [1:0] TAG_SEL_6 = 2'h2;
  localparam logic [5:0] RUN_LIMIT_4 = 6'h0e;
  localparam logic [5:0] RUN_LIMIT_5 = 6'h1e;
  localparam logic [5:0] RUN_LIMIT_6 = 6'h3e;
  localparam logic [3:0] HSYNC_AMP = 4'h5;
  localparam logic [3:0] VSYNC_AMP = 4'ha;
  localparam logic [9:0] SPARE_WORD = 10'h000;
  localparam logic [5:0] DIV_RESET = 6'h00;

  typedef enum logic [1:0] {ST_ACTIVE, ST_SYNC, ST_SPARE, ST_BLANKED} red_state_t;

  // clock cycles per sample period, rounded down; out of range reads as 1 MHz
  function automatic logic [5:0] period_cycles(input logic [3:0] rate);
    if (rate >= RATE_MIN_MHZ && rate <= RATE_MAX_MHZ)
    begin
      return 6'(CLK_FREQ_MHZ / int'(rate));
    end
    return 6'(CLK_FREQ_MHZ);
  endfunction : period_cycles
endpackage : reducer_pkg

// ---- rtl/word_fifo.sv ----
module word_fifo
  import reducer_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0] cnt;
    logic valid;
  } fifo_regs_t;

  fifo_regs_t s_q;
  fifo_regs_t s_d;
  logic [CW-1:0] n;

  // head entry sits in mem[0], so the read side comes straight from flops
  assign in_ready_out = (s_q.cnt != CW'(DEPTH));
  assign out_data_out = s_q.mem[0];
  assign out_valid_out = s_q.valid;

  always_comb
  begin
    s_d = s_q;
    n = s_q.cnt;
    if (s_q.valid && out_ready_in)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        s_d.mem[i] = s_q.mem[i+1];
      end
      s_d.mem[DEPTH-1] = '0;
      n = s_q.cnt - CW'(1);
    end
    if (in_valid_in && in_ready_out)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (CW'(i) == n)
        begin
          s_d.mem[i] = in_data_in;
        end
      end
      n = n + CW'(1);
    end
    s_d.cnt = n;
    s_d.valid = (n != '0);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  fifo_bound_a: assert property (@(posedge core_clk_in) disable iff (rst_in) s_q.cnt <= CW'(DEPTH))
    else $error("fifo count beyond depth");
endmodule : word_fifo

// ---- test/tx_buffer_model.sv ----
module tx_buffer_model
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [9:0] word_in,
  input wire logic word_valid_in,
  input wire logic stall_in,
  input wire logic hold_sync_in,
  input wire logic starve_in,
  output logic word_ready_out,
  output logic buf_ready_out,
  output logic underflow_out,
  output logic got_out,
  output logic [9:0] got_word_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // buffer side: all levels change just after the edge
  // ****************************************
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      word_ready_out <= 1'b0;
      buf_ready_out <= 1'b0;
      underflow_out <= 1'b0;
      got_out <= 1'b0;
      got_word_out <= 10'h000;
    end
    else
    begin
      word_ready_out <= !stall_in;
      buf_ready_out <= !hold_sync_in;
      underflow_out <= starve_in;
      got_out <= word_valid_in && word_ready_out;
      got_word_out <= word_in;
    end
  end
endmodule : tx_buffer_model

// ---- test/video_redundancy_reducer_tb_top.sv ----
module video_redundancy_reducer_tb_top
  import reducer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst, interp, adaptive, hblank, vblank, stall, hold_sync, starve;
  logic [3:0] rate, tol_fixed, fill_tol;
  logic [5:0] sample;
  logic [1:0] tag_size;
  logic [9:0] word, got_word;
  logic valid, ready, buf_ready, underflow, got;
  logic [9:0] seen[$];
  int error_cnt = 0;
  int n_tests = 0;

  video_redundancy_reducer dut (.core_clk_in(clk), .rst_in(rst), .rate_sel_in(rate), .sample_in(sample),
    .interpolator_mode_in(interp), .tag_size_in(tag_size), .tol_adaptive_in(adaptive),
    .tol_fixed_in(tol_fixed), .fill_tol_in(fill_tol), .hblank_in(hblank), .vblank_in(vblank),
    .buf_ready_in(buf_ready), .underflow_in(underflow), .word_out(word), .word_valid_out(valid),
    .word_ready_in(ready));

  tx_buffer_model far_end (.core_clk_in(clk), .rst_in(rst), .word_in(word), .word_valid_in(valid),
    .stall_in(stall), .hold_sync_in(hold_sync), .starve_in(starve), .word_ready_out(ready),
    .buf_ready_out(buf_ready), .underflow_out(underflow), .got_out(got), .got_word_out(got_word));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // collected away from the rising edge so reads never race the push
  always @(negedge clk)
  begin
    if (got === 1'b1)
      seen.push_back(got_word);
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk(input logic [9:0] got_v, input logic [9:0] exp_v);
    n_tests++;
    if (got_v !== exp_v)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    cyc(20000);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    logic [9:0] lim[3];
    rst = 1'b1;
    rate = 4'h9;
    sample = 6'h2b;
    interp = 1'b0;
    tag_size = TAG_SEL_4;
    adaptive = 1'b0;
    tol_fixed = 4'h0;
    fill_tol = 4'h0;
    hblank = 1'b0;
    vblank = 1'b0;
    stall = 1'b0;
    hold_sync = 1'b0;
    starve = 1'b0;
    cyc(2);
    rst <= 1'b0;
    // ****************************************
    // run limit and word packing per tag size
    // ****************************************
    lim[0] = {6'h2b, RUN_LIMIT_4[3:0]};
    lim[1] = {5'h15, RUN_LIMIT_5[4:0]};
    lim[2] = {4'ha, RUN_LIMIT_6};
    for (int i = 0; i < 3; i++)
    begin
      tag_size <= 2'(i);
      cyc(330);
      seen.delete();
      cyc(330);
      chk(seen[0], lim[i]);
    end
    $display("test run_limit done");
    // ****************************************
    // predictor against interpolator corridor
    // ****************************************
    for (int m = 0; m < 2; m++)
    begin
      interp <= m[0];
      tol_fixed <= 4'h2;
      tag_size <= TAG_SEL_4;
      sample <= 6'h10;
      cyc(30);
      seen.delete();
      sample <= 6'h13;
      cyc(15);
      sample <= 6'h30;
      cyc(15);
      chk(10'(seen.size()), m ? 10'h1 : 10'h2);
      chk(10'(seen[0][9:4]), m ? 10'h11 : 10'h10);
      if (m == 0)
        chk(10'(seen[1][9:4]), 10'h13);
    end
    $display("test modes done");
    // ****************************************
    // saturated bounds, fixed and adaptive tolerance
    // ****************************************
    for (int k = 0; k < 2; k++)
    begin
      adaptive <= !k[0];
      fill_tol <= k ? 4'h0 : 4'h4;
      tol_fixed <= k ? 4'h4 : 4'h0;
      sample <= k ? 6'h01 : 6'h3e;
      cyc(100);
      seen.delete();
      cyc(80);
      chk(seen[0], k ? {6'h02, 4'he} : {6'h3c, 4'he});
    end
    $display("test saturation done");
    // ****************************************
    // underflow forcing, then fifo fill and drain
    // ****************************************
    interp <= 1'b0;
    adaptive <= 1'b0;
    tol_fixed <= 4'h0;
    sample <= 6'h21;
    cyc(100);
    starve <= 1'b1;
    cyc(20);
    seen.delete();
    cyc(20);
    chk(seen[0], {6'h21, 4'h0});
    stall <= 1'b1;
    cyc(150);
    starve <= 1'b0;
    cyc(2);
    seen.delete();
    stall <= 1'b0;
    cyc(40);
    chk(10'(seen.size()), 10'(FIFO_DEPTH));
    $display("test underflow_fifo done");
    // ****************************************
    // blanking: flush, sync, spare, first sample
    // ****************************************
    for (int v = 0; v < 2; v++)
    begin
      tag_size <= v ? TAG_SEL_6 : TAG_SEL_4;
      sample <= 6'h15;
      cyc(100);
      hold_sync <= 1'b1;
      cyc(2);
      seen.delete();
      hblank <= 1'b1;
      vblank <= v[0];
      cyc(10);
      chk(10'(seen.size()), 10'h1);
      chk(10'(seen[0][9:6]), 10'h5);
      cyc(20);
      chk(10'(seen.size()), 10'h1);
      hold_sync <= 1'b0;
      cyc(10);
      chk(10'(seen.size()), 10'h3);
      chk(seen[1], {v ? VSYNC_AMP : HSYNC_AMP, 6'h00});
      chk(seen[2], SPARE_WORD);
      sample <= 6'h3c;
      cyc(10);
      seen.delete();
      hblank <= 1'b0;
      vblank <= 1'b0;
      cyc(20);
      sample <= 6'h05;
      cyc(15);
      chk(10'(seen.size()), 10'h1);
      chk(10'(seen[0][9:6]), 10'hf);
    end
    $display("test blanking done");
    // ****************************************
    // 5 MHz rate: one forced word per 15 ticks of 10 cycles; tag code 3
    // ****************************************
    rate <= 4'h5;
    tag_size <= 2'h3;
    cyc(200);
    seen.delete();
    cyc(150);
    chk(10'(seen.size()), 10'h1);
    chk(seen[0], {6'h05, RUN_LIMIT_4[3:0]});
    $display("test rate done");
    wrap_up();
  end
endmodule : video_redundancy_reducer_tb_top
